// [core/pll_synth_ref_select_lock_detect.sv]
// PLL synthesizer control: registers, input selection, phase detector, unlock and chip-enable logic
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Overview of operation
// - Four-bit code selects one of ten references
// - Compare divided phase against reference phase
// - Ref faster low, divided faster high, else float
// - Writing the mode register starts the synthesizer
// - Unlock flag set on unlock, unchanged when locked
// - Reading the unlock flag clears it
// - Chip enable low disables and floats outputs
// - Chip-enable status follows the pin level
// - Chip enable rise sets status, resets block
// - Chip enable fall clears status, raises interrupt
// - Only power-on reset sets the power flag
// - Writing zero clears the power-on flag
// - Method zero selects direct division, AM pin
// - Method one selects swallow division, FM pin
// - Counter reloads at zero; new data waits
// - Swallow counter picks 33, then 32 at zero
// - Upper twelve bits count, low four plus extra swallow
// ----------------------------------------------------------------
module pll_synth_ref_select_lock_detect #(
  parameter longint sys_clk_hz = pll_pkg::clk_hz_default
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_on_rstn,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic am_oscillator_input,
  input wire logic fm_oscillator_input,
  input wire logic chip_enable,
  output logic phase_error_out_a,
  output logic phase_error_out_a_oe,
  output logic phase_error_out_b,
  output logic phase_error_out_b_oe,
  output logic ce_interrupt
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rst_any;
  logic served;
  logic next_served;
  logic [31:0] next_readdata;
  logic capture;
  logic done;
  logic hit_ref;
  logic hit_mode;
  logic hit_data;
  logic [3:0] ref_sel;
  logic [3:0] next_ref_sel;
  pll_pkg::mode_reg_t mode_reg;
  pll_pkg::mode_reg_t next_mode_reg;
  logic [15:0] data_reg;
  logic [15:0] next_data_reg;
  logic start;
  logic next_start;
  logic power_on;
  logic next_power_on;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  logic ce_level;
  logic ce_rise;
  logic ce_fall;
  logic active;
  logic osc_edge;
  logic ref_tick;
  logic fn_tick;
  pll_pkg::pfd_state_t pfd_state;
  pll_pkg::pfd_state_t next_pfd_state;
  logic [1:0] fn_count;
  logic [1:0] next_fn_count;
  logic unlock_flag;
  logic next_unlock_flag;
  logic err_level;
  logic err_oe;
  logic next_err_level;
  logic next_err_oe;
  pll_pkg::ref_reg_t ref_view;

  // Power-on reset also acts as a full reset
  assign rst_any = !rstn || !power_on_rstn;

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  // Oscillator inputs are sampled, so they must stay below a quarter of sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev <= 3'h0;
    end else begin
      sync1 <= {chip_enable, fm_oscillator_input, am_oscillator_input};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign ce_level = sync2[2];
  assign ce_rise = pll_pkg::rose(sync2[2], prev[2]);
  assign ce_fall = pll_pkg::rose(prev[2], sync2[2]);
  // Method bit routes the AM or FM pin into the divider
  assign osc_edge = mode_reg.method ? pll_pkg::rose(sync2[1], prev[1]) : pll_pkg::rose(sync2[0], prev[0]);
  assign active = mode_reg.enable && ce_level;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then the transfer completes
  // ----------------------------------------------------------------
  assign hit_ref = address == pll_pkg::byte_addr(pll_pkg::ref_reg_index);
  assign hit_mode = address == pll_pkg::byte_addr(pll_pkg::mode_reg_index);
  assign hit_data = address == pll_pkg::byte_addr(pll_pkg::data_reg_index);
  assign capture = (read || write) && !served;
  assign done = (read || write) && served;
  assign waitrequest = (read || write) && !served;
  assign ref_view = '{unlock: unlock_flag, ce_status: ce_level, if_done: 1'b0, power_on: power_on, ref_sel: ref_sel};

  // Read data latched in the wait cycle; unmapped reads return zero
  always_comb begin
    next_served = capture;
    next_readdata = readdata;
    if (capture && read) begin
      if (hit_ref) begin
        next_readdata = {24'h0, ref_view};
      end else if (hit_mode) begin
        next_readdata = {24'h0, mode_reg};
      end else if (hit_data) begin
        next_readdata = {16'h0, data_reg};
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      served <= 1'b0;
      readdata <= 32'h0;
    end else begin
      served <= next_served;
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Chip-enable rise resets the mode; data and reference select survive it
  always_comb begin
    next_ref_sel = ref_sel;
    next_mode_reg = mode_reg;
    next_data_reg = data_reg;
    next_start = 1'b0;
    if (done && write && hit_ref && byteenable[0]) begin
      next_ref_sel = writedata[3:0];
    end
    if (done && write && hit_data) begin
      if (byteenable[0]) begin
        next_data_reg[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
        next_data_reg[15:8] = writedata[15:8];
      end
    end
    if (done && write && hit_mode && byteenable[0]) begin
      next_mode_reg = pll_pkg::mode_reg_t'(writedata[7:0]);
      next_mode_reg.unused = 1'b0;
      next_mode_reg.if_pend = 1'b0;
      next_mode_reg.ce_pend = mode_reg.ce_pend && writedata[0];
      next_start = 1'b1;
    end
    if (ce_rise) begin
      next_mode_reg = pll_pkg::mode_reg_t'(pll_pkg::mode_reg_reset);
      next_mode_reg.ce_pend = mode_reg.ce_pend;
      next_start = 1'b0;
    end
    // Hardware set wins over a clearing write
    if (ce_fall) begin
      next_mode_reg.ce_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      ref_sel <= pll_pkg::ref_reg_reset[3:0];
      mode_reg <= pll_pkg::mode_reg_t'(pll_pkg::mode_reg_reset);
      data_reg <= pll_pkg::data_reg_reset;
      start <= 1'b0;
    end else begin
      ref_sel <= next_ref_sel;
      mode_reg <= next_mode_reg;
      data_reg <= next_data_reg;
      start <= next_start;
    end
  end

  assign ce_interrupt = mode_reg.ce_pend && mode_reg.ce_int_en;

  // Power-on flag: only the power-on reset sets it
  always_comb begin
    next_power_on = power_on;
    if (rstn && done && write && hit_ref && byteenable[0] && !writedata[4]) begin
      next_power_on = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!power_on_rstn) begin
      power_on <= 1'b1;
    end else begin
      power_on <= next_power_on;
    end
  end

  // ----------------------------------------------------------------
  // Reference generator and programmable divider
  // ----------------------------------------------------------------
  ref_divider #(.sys_clk_hz(sys_clk_hz)) u_ref (
    .sys_clk(sys_clk),
    .rstn(!rst_any && !ce_rise),
    .run(active),
    .sel(ref_sel),
    .ref_tick(ref_tick)
  );

  prog_divider u_div (
    .sys_clk(sys_clk),
    .rstn(!rst_any && !ce_rise),
    .load(start),
    .run(active),
    .method(mode_reg.method),
    .osc_edge(osc_edge),
    .data(data_reg),
    .nf(mode_reg.nf),
    .fn_tick(fn_tick)
  );

  // ----------------------------------------------------------------
  // Phase detector, charge pump and unlock detector
  // ----------------------------------------------------------------
  // Three-state detector; the lagging edge returns it to equal
  always_comb begin
    next_pfd_state = pfd_state;
    next_fn_count = fn_count;
    next_unlock_flag = unlock_flag;
    if (!active || ce_rise) begin
      next_pfd_state = pll_pkg::pfd_equal;
      next_fn_count = 2'h0;
    end else begin
      case (pfd_state)
        pll_pkg::pfd_equal: begin
          if (ref_tick && !fn_tick) begin
            next_pfd_state = pll_pkg::pfd_ref_ahead;
          end else if (fn_tick && !ref_tick) begin
            next_pfd_state = pll_pkg::pfd_div_ahead;
          end
        end
        pll_pkg::pfd_ref_ahead: begin
          if (fn_tick && !ref_tick) begin
            next_pfd_state = pll_pkg::pfd_equal;
          end
        end
        pll_pkg::pfd_div_ahead: begin
          if (ref_tick && !fn_tick) begin
            next_pfd_state = pll_pkg::pfd_equal;
          end
        end
        default: next_pfd_state = pll_pkg::pfd_equal;
      endcase
      if (ref_tick) begin
        next_fn_count = {1'b0, fn_tick};
      end else if (fn_tick && fn_count != 2'h2) begin
        next_fn_count = 2'(fn_count + 2'h1);
      end
    end
    // Read clears; a same-cycle unlock verdict still sets
    if (capture && read && hit_ref) begin
      next_unlock_flag = 1'b0;
    end
    if (active && ref_tick && fn_count != 2'h1) begin
      next_unlock_flag = 1'b1;
    end
    next_err_oe = active && next_pfd_state != pll_pkg::pfd_equal;
    next_err_level = next_pfd_state == pll_pkg::pfd_div_ahead;
  end

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      pfd_state <= pll_pkg::pfd_equal;
      fn_count <= 2'h0;
      unlock_flag <= 1'b0;
      err_level <= 1'b0;
      err_oe <= 1'b0;
    end else begin
      pfd_state <= next_pfd_state;
      fn_count <= next_fn_count;
      unlock_flag <= next_unlock_flag;
      err_level <= next_err_level;
      err_oe <= next_err_oe;
    end
  end

  // Both error pins carry the same pump output
  assign phase_error_out_a = err_level;
  assign phase_error_out_b = err_level;
  assign phase_error_out_a_oe = err_oe;
  assign phase_error_out_b_oe = err_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pump_drive_low: assert property (@(posedge sys_clk) disable iff (rst_any)
    (pfd_state == pll_pkg::pfd_ref_ahead) |-> err_oe && !err_level) else $error("pump not low");

  a_pump_drive_high: assert property (@(posedge sys_clk) disable iff (rst_any)
    (pfd_state == pll_pkg::pfd_div_ahead) |-> err_oe && err_level) else $error("pump not high");

  a_ce_low_float: assert property (@(posedge sys_clk) disable iff (rst_any)
    !ce_level [*2] |-> !phase_error_out_a_oe && !phase_error_out_b_oe) else $error("pins driven while disabled");

  a_unlock_set: assert property (@(posedge sys_clk) disable iff (rst_any)
    (active && ref_tick && fn_count != 2'h1) |=> unlock_flag) else $error("unlock not flagged");

  a_unlock_read_clear: assert property (@(posedge sys_clk) disable iff (rst_any)
    (capture && read && hit_ref && !(active && ref_tick && fn_count != 2'h1)) |=> !unlock_flag)
    else $error("unlock not cleared by read");

  a_ce_fall_pend: assert property (@(posedge sys_clk) disable iff (rst_any)
    $fell(ce_level) |=> mode_reg.ce_pend) else $error("no pending bit on chip-enable fall");

  a_ce_rise_reset: assert property (@(posedge sys_clk) disable iff (rst_any)
    ce_rise |=> !mode_reg.enable && !err_oe) else $error("chip-enable reset missing");

  a_pof_kept: assert property (@(posedge sys_clk) disable iff (!power_on_rstn)
    !rstn |=> power_on == $past(power_on)) else $error("power-on flag touched by reset");

  a_pof_clear: assert property (@(posedge sys_clk) disable iff (rst_any)
    (done && write && hit_ref && byteenable[0] && !writedata[4]) |=> !power_on) else $error("power-on flag kept");

  a_mode_start: assert property (@(posedge sys_clk) disable iff (rst_any)
    (done && write && hit_mode && byteenable[0] && !ce_rise) |=> start ##1 !start) else $error("no start pulse");
endmodule

// [core/pll_pkg.sv]
// Shared constants, register layouts and helper functions for the PLL synthesizer control
package pll_pkg;

  // ----------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] ref_reg_index = 8'hf9;
  localparam logic [7:0] mode_reg_index = 8'hf8;
  localparam logic [7:0] data_reg_index = 8'hf7;
  localparam logic [7:0] ref_reg_reset = 8'h00;
  localparam logic [7:0] mode_reg_reset = 8'h00;
  localparam logic [15:0] data_reg_reset = 16'h0000;

  // ----------------------------------------------------------------
  // Divider layout and timing
  // ----------------------------------------------------------------
  localparam logic [5:0] presc_last_33 = 6'h20;
  localparam logic [5:0] presc_last_32 = 6'h1f;
  localparam longint clk_hz_default = 64'h5f5e100;
  localparam longint centi_per_hz = 64'h64;
  localparam logic [3:0] ref_sel_last = 4'h9;

  // Register fields
  typedef struct packed {
    logic unlock;
    logic ce_status;
    logic if_done;
    logic power_on;
    logic [3:0] ref_sel;
  } ref_reg_t;

  typedef struct packed {
    logic method;
    logic enable;
    logic nf;
    logic unused;
    logic if_int_en;
    logic if_pend;
    logic ce_int_en;
    logic ce_pend;
  } mode_reg_t;

  typedef enum logic [1:0] {
    pfd_equal = 2'b00,
    pfd_ref_ahead = 2'b01,
    pfd_div_ahead = 2'b10
  } pfd_state_t;

  // Word-aligned byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Rising edge of a synchronised level
  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Reference period in system clocks; zero for the reserved codes
  function automatic logic [16:0] ref_cycles(input logic [3:0] sel, input longint clk_hz);
    longint chz;
    chz = 64'h0;
    case (sel)
      4'h0: chz = 64'h186a0;
      4'h1: chz = 64'h493e0;
      4'h2: chz = 64'h7a120;
      4'h3: chz = 64'h98968;
      4'h4: chz = 64'hdbba0;
      4'h5: chz = 64'hf4240;
      4'h6: chz = 64'h1312d0;
      4'h7: chz = 64'h2625a0;
      4'h8: chz = 64'h4c4b40;
      4'h9: chz = 64'h989680;
      default: chz = 64'h0;
    endcase
    if (chz == 64'h0) begin
      return 17'h0;
    end
    return 17'(clk_hz * centi_per_hz / chz);
  endfunction

endpackage

// [core/ref_divider.sv]
// Reference frequency generator: one tick per selected reference period
`timescale 1ns/100ps
module ref_divider #(
  parameter longint sys_clk_hz = pll_pkg::clk_hz_default
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [3:0] sel,
  output logic ref_tick
);
  logic [16:0] count;
  logic [16:0] next_count;
  logic [16:0] limit;
  logic next_tick;

  // Reserved codes give a zero limit and stop the generator
  assign limit = pll_pkg::ref_cycles(sel, sys_clk_hz);

  // Period counter
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (!run || limit == 17'h0) begin
      next_count = 17'h0;
    end else if (count >= 17'(limit - 17'h1)) begin
      next_count = 17'h0;
      next_tick = 1'b1;
    end else begin
      next_count = 17'(count + 17'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count <= 17'h0;
      ref_tick <= 1'b0;
    end else begin
      count <= next_count;
      ref_tick <= next_tick;
    end
  end

  a_ref_tick_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
    ref_tick |=> !ref_tick [*8]) else $error("reference ticks closer than nine cycles");

  a_reserved_silent: assert property (@(posedge sys_clk) disable iff (!rstn)
    (sel > pll_pkg::ref_sel_last) [*2] |-> !ref_tick) else $error("reference tick on reserved code");
endmodule

// [core/prog_divider.sv]
// Programmable divider: 12-bit down counter with 5-bit swallow counter and 32/33 prescaler
`timescale 1ns/100ps
module prog_divider (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic run,
  input wire logic method,
  input wire logic osc_edge,
  input wire logic [15:0] data,
  input wire logic nf,
  output logic fn_tick
);
  logic [11:0] prog_cnt;
  logic [11:0] next_prog_cnt;
  logic [4:0] swallow_cnt;
  logic [4:0] next_swallow_cnt;
  logic [5:0] presc_cnt;
  logic [5:0] next_presc_cnt;
  logic next_fn_tick;
  logic step;

  // Counting; apart from a load pulse, reload happens only at terminal count so new data waits
  always_comb begin
    next_prog_cnt = prog_cnt;
    next_swallow_cnt = swallow_cnt;
    next_presc_cnt = presc_cnt;
    next_fn_tick = 1'b0;
    step = 1'b0;
    if (load) begin
      next_prog_cnt = data[15:4];
      next_swallow_cnt = {data[3:0], nf};
      next_presc_cnt = 6'h0;
    end else if (run && osc_edge) begin
      if (!method) begin
        step = 1'b1;
      end else if (presc_cnt >= ((swallow_cnt != 5'h0) ? pll_pkg::presc_last_33 : pll_pkg::presc_last_32)) begin
        step = 1'b1;
        next_presc_cnt = 6'h0;
      end else begin
        next_presc_cnt = 6'(presc_cnt + 6'h1);
      end
      if (step) begin
        if (prog_cnt <= 12'h1) begin
          next_prog_cnt = data[15:4];
          next_swallow_cnt = {data[3:0], nf};
          next_fn_tick = 1'b1;
        end else begin
          next_prog_cnt = 12'(prog_cnt - 12'h1);
          if (method && swallow_cnt != 5'h0) begin
            next_swallow_cnt = 5'(swallow_cnt - 5'h1);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prog_cnt <= 12'h0;
      swallow_cnt <= 5'h0;
      presc_cnt <= 6'h0;
      fn_tick <= 1'b0;
    end else begin
      prog_cnt <= next_prog_cnt;
      swallow_cnt <= next_swallow_cnt;
      presc_cnt <= next_presc_cnt;
      fn_tick <= next_fn_tick;
    end
  end

  a_reload_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    fn_tick |-> prog_cnt == $past(data[15:4])) else $error("counter not reloaded from data");

  a_swallow_33: assert property (@(posedge sys_clk) disable iff (!rstn)
    (run && method && osc_edge && !load && swallow_cnt != 5'h0 && presc_cnt == pll_pkg::presc_last_32)
    |=> presc_cnt == pll_pkg::presc_last_33) else $error("prescaler not 33 while swallowing");
endmodule

// [tb/vco_model.sv]
// Behavioural oscillator that stands beyond the loop filter and feeds the divider pins
`timescale 1ns/100ps
module vco_model (
  input wire logic sys_clk,
  input wire logic fm_sel,
  input wire logic [7:0] period,
  output logic am_out,
  output logic fm_out
);
  // ----------------------------------------------------------------
  // Oscillator
  // ----------------------------------------------------------------
  logic [7:0] phase = 8'h00;
  logic wave;
  // Free-running square wave; period counted in system clocks
  always_ff @(posedge sys_clk) begin
    phase <= (phase >= period - 8'h01) ? 8'h00 : phase + 8'h01;
  end
  assign wave = phase < (period >> 1);
  // The idle pin is pulled low, so a wrong pin choice sees no edges at all
  assign am_out = wave & ~fm_sel;
  assign fm_out = wave & fm_sel;
endmodule

// [tb/test_pll_synth_ref_select_lock_detect.sv]
// Register-level tests of the PLL synthesizer control block
`timescale 1ns/100ps
module test_pll_synth_ref_select_lock_detect;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  localparam logic [11:0] ref_a = 12'h3e4;
  localparam logic [11:0] mode_a = 12'h3e0;
  localparam logic [11:0] data_a = 12'h3dc;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_on_rstn = 1'b0;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic chip_enable = 1'b1;
  logic fm_sel = 1'b0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest, am_in, fm_in, eo_a, eo_a_oe, eo_b, eo_b_oe, ce_int;
  int n_errors = 0;
  int n_tests = 0;

  always #5 sys_clk = ~sys_clk;

  // Short reference counts: 25 kHz is 200 clocks, 1 kHz is 5000
  pll_synth_ref_select_lock_detect #(.sys_clk_hz(5000000)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .power_on_rstn(power_on_rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .am_oscillator_input(am_in), .fm_oscillator_input(fm_in),
    .chip_enable(chip_enable), .phase_error_out_a(eo_a), .phase_error_out_a_oe(eo_a_oe),
    .phase_error_out_b(eo_b), .phase_error_out_b_oe(eo_b_oe), .ce_interrupt(ce_int));

  // Oscillator period of 5 clocks stays below a quarter of the system clock
  vco_model vco (.sys_clk(sys_clk), .fm_sel(fm_sel), .period(8'h05), .am_out(am_in), .fm_out(fm_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One bus transfer; request held until waitrequest is seen low at an edge
  task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rst(input logic po);
    rstn <= 1'b0;
    power_on_rstn <= ~po;
    cyc(3);
    rstn <= 1'b1;
    power_on_rstn <= 1'b1;
    cyc(5);
  endtask

  // Retune the divider, then look at the pump once it drives
  task automatic tune(input logic [31:0] d, input logic lvl);
    rw(1'b1, data_a, d);
    cyc(600);
    @(negedge sys_clk);
    for (int i = 0; i < 600 && eo_a_oe !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    chk("pump_oe", {31'h0, eo_a_oe & eo_b_oe}, 32'h1);
    chk("pump_a", {31'h0, eo_a}, {31'h0, lvl});
    chk("pump_b", {31'h0, eo_b}, {31'h0, lvl});
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst(1'b1);
    rw(1'b0, ref_a, 32'h0);
    chk("ref_por", rd, 32'h50);
    rw(1'b1, ref_a, 32'h0);
    rw(1'b0, ref_a, 32'h0);
    chk("po_clear", rd, 32'h40);
    rst(1'b0);
    rw(1'b0, ref_a, 32'h0);
    chk("po_kept", rd, 32'h40);
    for (int i = 0; i < 11; i++) begin
      rw(1'b1, ref_a, 32'(i));
      rw(1'b0, ref_a, 32'h0);
      chk("ref_sel", rd, 32'h40 | 32'(i));
    end
    rw(1'b0, 12'h100, 32'h0);
    chk("unmapped", rd, 32'h0);
    rw(1'b1, ref_a, 32'h82);
    rw(1'b0, ref_a, 32'h0);
    chk("ref_ro", rd, 32'h42);
    // Direct division: 40 edges of 5 clocks match one 200-clock period
    rw(1'b1, mode_a, 32'h42);
    rw(1'b1, ref_a, 32'h07);
    rw(1'b1, data_a, 32'h280);
    rw(1'b1, mode_a, 32'h42);
    cyc(600);
    rw(1'b0, ref_a, 32'h0);
    cyc(400);
    rw(1'b0, ref_a, 32'h0);
    chk("am_lock", rd, 32'h47);
    tune(32'h1e0, 1'b1);
    // Stop the detector first so no fresh verdict lands between the two reads
    rw(1'b1, mode_a, 32'h02);
    rw(1'b0, ref_a, 32'h0);
    chk("unlock", rd, 32'hc7);
    rw(1'b0, ref_a, 32'h0);
    chk("unlock_clr", rd, 32'h47);
    rw(1'b1, mode_a, 32'h42);
    tune(32'h320, 1'b0);
    // Swallow division: 32*31+8 edges of 5 clocks match 5000 clocks; M must stay below N
    fm_sel <= 1'b1;
    rw(1'b1, mode_a, 32'hc2);
    rw(1'b1, ref_a, 32'h00);
    rw(1'b1, data_a, 32'h1f4);
    rw(1'b1, mode_a, 32'hc2);
    cyc(5200);
    rw(1'b0, ref_a, 32'h0);
    cyc(5200);
    rw(1'b0, ref_a, 32'h0);
    chk("fm_lock", rd, 32'h40);
    // Chip enable falls, then rises again
    chip_enable <= 1'b0;
    cyc(8);
    rw(1'b0, ref_a, 32'h0);
    chk("ce_low", rd & 32'h7f, 32'h0);
    @(negedge sys_clk);
    chk("ce_float", {31'h0, eo_a_oe | eo_b_oe}, 32'h0);
    chk("ce_int", {31'h0, ce_int}, 32'h1);
    @(posedge sys_clk);
    rw(1'b0, mode_a, 32'h0);
    chk("ce_pend", rd, 32'hc3);
    rw(1'b1, mode_a, 32'h02);
    @(negedge sys_clk);
    chk("ce_int_clr", {31'h0, ce_int}, 32'h0);
    @(posedge sys_clk);
    chip_enable <= 1'b1;
    cyc(8);
    rw(1'b0, mode_a, 32'h0);
    chk("ce_reset", rd, 32'h0);
    rw(1'b0, ref_a, 32'h0);
    chk("ce_high", rd & 32'h7f, 32'h40);
    cyc(400);
    @(negedge sys_clk);
    chk("idle_float", {31'h0, eo_a_oe | eo_b_oe}, 32'h0);
    results();
  end

  // Watchdog well beyond the roughly 13500 clocks the tests take
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    results();
  end
endmodule
